// *** pkg/pcrg_pkg.sv ***
package pcrg_pkg;
   // divide-by-three phase of the processor clock
   localparam logic [1:0] PCRG_DIV_HIGH_PH = 2'h0;
   localparam logic [1:0] PCRG_DIV_LAST_PH = 2'h2;
   localparam logic [1:0] PCRG_DIV_RST     = 2'h0;
   // reset values
   localparam logic       PCRG_CLK_RST     = 1'b0;
   localparam logic       PCRG_PCLK_RST    = 1'b0;
   localparam logic       PCRG_READY_RST   = 1'b0;
   localparam logic       PCRG_RESET_RST   = 1'b1;
endpackage

// *** hw/pcrg_sync2.sv ***
`timescale 1ns/1ns
module pcrg_sync2
   import pcrg_pkg::*;
(
   input  wire logic clk,    // system clock
   input  wire logic rst,    // synchronous reset
   input  wire logic d,      // asynchronous level
   output logic      q       // synchronised level
);
   typedef struct packed {
      logic s1;
      logic s2;
   } pcrg_sync_t;

   pcrg_sync_t st_r;
   pcrg_sync_t st_nxt;

   // only the second stage reads the first
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.s2;
endmodule

// *** hw/pcrg_top.sv ***
`timescale 1ns/1ns
module pcrg_top
   import pcrg_pkg::*;
(
   input  wire logic clk,                      // system clock
   input  wire logic rst,                      // synchronous reset
   input  wire logic crystal_pins,             // crystal oscillator level
   input  wire logic external_frequency_input, // external source level
   input  wire logic source_select,            // strap, high selects crystal
   input  wire logic divider_sync_clear,       // holds divider cleared
   input  wire logic ready_qualifier_one_n,    // qualifier for bus ready one
   input  wire logic ready_qualifier_two_n,    // qualifier for bus ready two
   input  wire logic bus_ready_one,            // bus ready one
   input  wire logic bus_ready_two,            // bus ready two
   input  wire logic power_on_trigger_input,   // reset trigger input
   output logic      crystal_rate_output,      // crystal rate copy
   output logic      proc_clk,                 // processor clock
   output logic      periph_clk,               // peripheral clock
   output logic      ready_out,                // synchronised ready
   output logic      reset_out                 // synchronised reset
);
   typedef struct packed {
      logic       xtal_d;
      logic       xtal_q;
      logic       efi_d;
      logic       efi_q;
      logic       sel_d;
      logic       sel_q;
      logic       src_prev;
      logic [1:0] phase;
      logic [1:0] phase_prev;
      logic       clk_o;
      logic       pclk_o;
      logic       osc_o;
      logic       rdy_s1;
      logic       rdy_s2;
      logic       res_o;
   } pcrg_state_t;

   pcrg_state_t st_r;
   pcrg_state_t st_nxt;
   logic        sync_q;
   logic        bus_ready_one_q;
   logic        bus_ready_two_q;
   logic        ready_qualifier_one_n_q;
   logic        ready_qualifier_two_n_q;
   logic        res_q;
   logic        src;
   logic        src_rise;
   logic        clk_fall;
   logic        clk_rise;

   // level inputs from pins, two flops each before any logic
   pcrg_sync2 u_sync (.clk(clk), .rst(rst), .d(divider_sync_clear), .q(sync_q));
   pcrg_sync2 u_bus_ready_one (.clk(clk), .rst(rst), .d(bus_ready_one), .q(bus_ready_one_q));
   pcrg_sync2 u_bus_ready_two (.clk(clk), .rst(rst), .d(bus_ready_two), .q(bus_ready_two_q));
   pcrg_sync2 u_ready_qualifier_one_n (.clk(clk), .rst(rst), .d(ready_qualifier_one_n), .q(ready_qualifier_one_n_q));
   pcrg_sync2 u_ready_qualifier_two_n (.clk(clk), .rst(rst), .d(ready_qualifier_two_n), .q(ready_qualifier_two_n_q));
   pcrg_sync2 u_res  (.clk(clk), .rst(rst), .d(power_on_trigger_input), .q(res_q));

   function automatic logic qual(input logic rdy, input logic aen_n);
      qual = rdy & ~aen_n;
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.xtal_d = crystal_pins;
      st_nxt.xtal_q = st_r.xtal_d;
      st_nxt.efi_d  = external_frequency_input;
      st_nxt.efi_q  = st_r.efi_d;
      st_nxt.sel_d  = source_select;
      st_nxt.sel_q  = st_r.sel_d;
      // a strap change can fake one source edge; the divider takes it
      src      = st_r.sel_q ? st_r.xtal_q : st_r.efi_q;
      src_rise = src & ~st_r.src_prev;
      clk_rise = 1'b0;
      clk_fall = 1'b0;
      st_nxt.src_prev = src;
      st_nxt.phase_prev = st_r.phase;
      st_nxt.osc_o    = st_r.xtal_q;
      if (sync_q)
      begin
         st_nxt.phase = PCRG_DIV_RST;
         st_nxt.clk_o = PCRG_CLK_RST;
         st_nxt.pclk_o = PCRG_PCLK_RST;
      end
      else if (src_rise)
      begin
         // one high source cycle, then two low
         st_nxt.phase = (st_r.phase == PCRG_DIV_LAST_PH) ? PCRG_DIV_HIGH_PH
                                                         : st_r.phase + 2'h1;
         st_nxt.clk_o = (st_nxt.phase == PCRG_DIV_HIGH_PH);
         clk_rise = st_nxt.clk_o & ~st_r.clk_o;
         clk_fall = ~st_nxt.clk_o & st_r.clk_o;
         if (clk_rise)
            st_nxt.pclk_o = ~st_r.pclk_o;
      end
      if (clk_fall)
      begin
         // second stage, ready rises and drops only on clock fall
         st_nxt.rdy_s1 = qual(bus_ready_one_q, ready_qualifier_one_n_q) | qual(bus_ready_two_q, ready_qualifier_two_n_q);
         st_nxt.rdy_s2 = st_r.rdy_s1;
         st_nxt.res_o  = res_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r        <= '0;
         st_r.phase  <= PCRG_DIV_RST;
         st_r.clk_o  <= PCRG_CLK_RST;
         st_r.pclk_o <= PCRG_PCLK_RST;
         st_r.rdy_s2 <= PCRG_READY_RST;
         st_r.res_o  <= PCRG_RESET_RST;
      end
      else
         st_r <= st_nxt;
   end

   assign crystal_rate_output = st_r.osc_o;
   assign proc_clk            = st_r.clk_o;
   assign periph_clk          = st_r.pclk_o;
   assign ready_out           = st_r.rdy_s2;
   assign reset_out           = st_r.res_o;

   // assertions
   // a processor clock edge made by the divider, not forced by the sync clear
   sequence seq_div_rise;
      $rose(proc_clk) && !$past(sync_q);
   endsequence

   sequence seq_div_fall;
      $fell(proc_clk) && !$past(sync_q);
   endsequence

   // a source rise while the divider runs
   sequence seq_src_step;
      $past(src_rise) && !$past(sync_q);
   endsequence

   chk_sync_holds_div: assert property (@(posedge clk) disable iff (rst)
      sync_q |=> (st_r.phase == PCRG_DIV_RST) && !proc_clk)
      else $error("divider not held by sync");
   chk_clk_high_phase: assert property (@(posedge clk) disable iff (rst)
      proc_clk |-> st_r.phase == PCRG_DIV_HIGH_PH)
      else $error("clock high outside first phase");
   chk_phase_bound: assert property (@(posedge clk) disable iff (rst)
      st_r.phase <= PCRG_DIV_LAST_PH)
      else $error("phase out of range");
   chk_phase_step: assert property (@(posedge clk) disable iff (rst)
      (st_r.phase != $past(st_r.phase) && !$past(sync_q)) |->
      st_r.phase == (($past(st_r.phase) == PCRG_DIV_LAST_PH) ? PCRG_DIV_HIGH_PH
                     : $past(st_r.phase) + 2'h1))
      else $error("divider skipped a phase");
   chk_pclk_on_rise: assert property (@(posedge clk) disable iff (rst)
      $changed(periph_clk) && !$past(sync_q) |-> $rose(proc_clk))
      else $error("peripheral clock toggled off rise");
   chk_ready_on_fall: assert property (@(posedge clk) disable iff (rst)
      $changed(ready_out) |-> $fell(proc_clk))
      else $error("ready changed off clock fall");
   chk_reset_on_fall: assert property (@(posedge clk) disable iff (rst)
      $changed(reset_out) |-> $fell(proc_clk))
      else $error("reset changed off clock fall");
   chk_osc_follows: assert property (@(posedge clk) disable iff (rst)
      ##1 crystal_rate_output == $past(st_r.xtal_q))
      else $error("oscillator output lags wrongly");

   chk_pclk_each_rise: assert property (@(posedge clk) disable iff (rst)
      seq_div_rise |-> $changed(periph_clk))
      else $error("peripheral clock missed a toggle");
   chk_pclk_fall_hold: assert property (@(posedge clk) disable iff (rst)
      seq_div_fall |-> $stable(periph_clk))
      else $error("peripheral clock toggled on clock fall");
   chk_rise_from_last: assert property (@(posedge clk) disable iff (rst)
      seq_div_rise |-> st_r.phase_prev == PCRG_DIV_LAST_PH)
      else $error("clock rose before two low source cycles");
   chk_fall_after_high: assert property (@(posedge clk) disable iff (rst)
      seq_div_fall |-> st_r.phase_prev == PCRG_DIV_HIGH_PH)
      else $error("clock high longer than one source cycle");
   chk_src_advances: assert property (@(posedge clk) disable iff (rst)
      seq_src_step |-> st_r.phase != st_r.phase_prev)
      else $error("source rise did not advance divider");
   chk_phase_on_src: assert property (@(posedge clk) disable iff (rst)
      st_r.phase != st_r.phase_prev |-> $past(src_rise) || $past(sync_q))
      else $error("divider moved without a source rise");
   chk_sync_pclk_low: assert property (@(posedge clk) disable iff (rst)
      sync_q |=> !periph_clk)
      else $error("peripheral clock not held by sync");

   chk_ready_first_stage: assert property (@(posedge clk) disable iff (rst)
      seq_div_fall |->
      st_r.rdy_s1 == $past((bus_ready_one_q && !ready_qualifier_one_n_q) || (bus_ready_two_q && !ready_qualifier_two_n_q)))
      else $error("ready input not qualified");
   chk_ready_second_stage: assert property (@(posedge clk) disable iff (rst)
      seq_div_fall |-> ready_out == $past(st_r.rdy_s1))
      else $error("ready skipped its second stage");
   chk_ready_sync_hold: assert property (@(posedge clk) disable iff (rst)
      sync_q |=> $stable(ready_out))
      else $error("ready moved while divider held");
   chk_reset_follows_in: assert property (@(posedge clk) disable iff (rst)
      seq_div_fall |-> reset_out == $past(res_q))
      else $error("reset output does not follow input");
endmodule

// *** sim/pcrg_src_model.sv ***
`timescale 1ns/1ns
module pcrg_src_model #(
   parameter int XHALF = 4, // crystal half period, clk cycles
   parameter int EHALF = 6  // external half period, clk cycles
)(
   input  wire logic clk,      // system clock
   output logic      xtal_lvl, // crystal level
   output logic      ext_lvl   // external source level
);
   int   xc   = 0;
   int   ec   = 0;
   logic xt_r = 1'b0;
   logic ex_r = 1'b0;
   // square waves, slow enough for the input synchronisers
   always @(posedge clk)
   begin
      xc <= (xc == XHALF - 1) ? 0 : xc + 1;
      ec <= (ec == EHALF - 1) ? 0 : ec + 1;
      if (xc == XHALF - 1)
         xt_r <= ~xt_r;
      if (ec == EHALF - 1)
         ex_r <= ~ex_r;
   end
   assign xtal_lvl = xt_r;
   assign ext_lvl  = ex_r;
endmodule

// *** sim/tb_processor_clock_ready_reset_gen.sv ***
`timescale 1ns/1ns
module tb_processor_clock_ready_reset_gen;
   import pcrg_pkg::*;
   logic clk = 0, rst = 1, sel = 1, sclr = 0, q1 = 0, q2 = 0, r1 = 0, r2 = 0, por = 0;
   logic xt, ex, osc, pc, pk, rdy, rso;
   int fail_count = 0, tests_run = 0, cyc = 0;
   always #25 clk = ~clk;
   pcrg_src_model src_u (.clk(clk), .xtal_lvl(xt), .ext_lvl(ex));
   pcrg_top dut_u (.clk(clk), .rst(rst), .crystal_pins(xt), .external_frequency_input(ex),
      .source_select(sel), .divider_sync_clear(sclr), .ready_qualifier_one_n(q1),
      .ready_qualifier_two_n(q2), .bus_ready_one(r1), .bus_ready_two(r2),
      .power_on_trigger_input(por), .crystal_rate_output(osc), .proc_clk(pc),
      .periph_clk(pk), .ready_out(rdy), .reset_out(rso));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic pick(input logic [1:0] s);
      return (s == 2'h0) ? pc : (s == 2'h1) ? pk : osc;
   endfunction
   // counts cycles while the chosen output holds v, capped at fa
   task automatic span(input logic [1:0] s, input logic v, output logic [7:0] c);
      c = 8'h00;
      while (pick(s) === v && c < 8'hfa)
      begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic t_meas(input logic [1:0] s, input logic [7:0] eh, input logic [7:0] el);
      logic [7:0] hi, lo;
      span(s, 1'b1, hi);
      span(s, 1'b0, lo);
      span(s, 1'b1, hi);
      span(s, 1'b0, lo);
      chk(hi, eh);
      chk(lo, el);
   endtask
   task automatic t_rdy(input logic a, b, c, d, e);
      @(posedge clk);
      q1 <= a;
      r1 <= b;
      q2 <= c;
      r2 <= d;
      repeat (80) @(negedge clk);
      chk(rdy, e);
   endtask
   task automatic t_rst_vals;
      @(negedge clk);
      chk(rso, PCRG_RESET_RST);
      chk(pc, PCRG_CLK_RST);
      chk(pk, PCRG_PCLK_RST);
      chk(rdy, PCRG_READY_RST);
   endtask
   task automatic t_hold;
      @(posedge clk);
      r2 <= 1'b0;
      repeat (5) @(negedge clk);
      chk(rdy, 1'b1);
   endtask
   task automatic t_por(input logic v);
      @(posedge clk);
      por <= v;
      repeat (80) @(negedge clk);
      chk(rso, v);
   endtask
   task automatic t_ext;
      @(posedge clk);
      sel <= 1'b0;
      repeat (40) @(negedge clk);
   endtask
   task automatic t_sync;
      logic [7:0] n;
      @(posedge clk);
      sclr <= 1'b1; // clears the divider whichever source is selected; here the external one
      repeat (30) @(negedge clk);
      span(2'h0, 1'b0, n);
      chk(n, 8'hfa);
      chk(pk, PCRG_PCLK_RST);
      @(posedge clk);
      sclr <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_rst_vals();
      t_meas(2'h0, 8'h08, 8'h10);
      t_meas(2'h1, 8'h18, 8'h18);
      t_rdy(1, 1, 1, 1, 0);
      t_rdy(0, 1, 0, 0, 1);
      t_rdy(0, 1, 1, 0, 1);
      t_rdy(1, 0, 0, 1, 1);
      t_hold();
      t_rdy(0, 0, 0, 0, 0);
      t_por(1'b1);
      t_por(1'b0);
      t_ext();
      t_meas(2'h0, 8'h0c, 8'h18);
      t_sync();
      t_meas(2'h0, 8'h0c, 8'h18);
      t_meas(2'h2, 8'h04, 8'h04);
      close_out();
   end
endmodule
